// ===== e3s_rx_status_latch_irq.sv
// Receive status, latched change/event flags and interrupt enables of one port
module e3s_rx_status_latch_irq
  import e3s_pkg::*;
#(
  parameter int ALIGN_W = 16
) (
  input  wire logic                          mclk,
  input  wire logic                          reset,
  input  wire logic                          ce,
  // Wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [e3s_pkg::WB_AW-1:0]     wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [e3s_pkg::WB_DW-1:0]     wb_dat_i,
  output logic      [e3s_pkg::WB_DW-1:0]     wb_dat_o,
  output logic                               wb_ack_o,
  // Receive framer status
  input  wire logic                          signal_absent_pin,
  input  wire logic                          frame_lost,
  input  wire logic                          remote_defect,
  input  wire logic                          alarm_ind,
  input  wire logic                          out_of_frame,
  input  wire logic                          unframed_all_ones,
  input  wire logic                          payload_unstable,
  input  wire logic [2:0]                    payload_type,
  input  wire logic [3:0]                    timing_source,
  input  wire logic [7:0]                    gc_byte_value,
  input  wire logic [7:0]                    nr_byte_value,
  input  wire logic                          align_load,
  input  wire logic [ALIGN_W-1:0]            align_value,
  input  wire logic                          remote_err_event,
  input  wire logic                          parity_err_event,
  input  wire logic                          framing_err_event,
  input  wire logic [e3s_pkg::CNT_W-1:0]     remote_err_count,
  input  wire logic [e3s_pkg::CNT_W-1:0]     parity_err_count,
  input  wire logic [e3s_pkg::CNT_W-1:0]     framing_err_count,
  // Status outputs
  output logic                               payload_mismatch,
  output logic                               port_irq
);

  // ==========================================================================
  // Helpers
  function automatic logic rise(input logic now, input logic was);
    rise = now & ~was;
  endfunction

  function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old,
                                                   input logic [DATA_W-1:0] wdat,
                                                   input logic [1:0]        sel);
    lane_merge[7:0]  = sel[0] ? wdat[7:0]  : old[7:0];
    lane_merge[15:8] = sel[1] ? wdat[15:8] : old[15:8];
  endfunction

  function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] sel);
    lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // ==========================================================================
  // Bus decode
  logic [IDX_W-1:0]  bus_idx;
  logic [DATA_W-1:0] bus_wdat;
  logic [1:0]        bus_sel;
  logic              bus_req;
  logic              wr_take;

  assign bus_idx  = wb_adr_i[IDX_W+1:2];
  assign bus_wdat = wb_dat_i[DATA_W-1:0];
  assign bus_sel  = wb_sel_i[1:0];
  assign bus_req  = wb_cyc_i & wb_stb_i;
  assign wr_take  = bus_req & wb_we_i & wb_ack_o;

  // ==========================================================================
  // Sampled status
  logic              primed;
  logic              los_now;
  logic              lof_now;
  logic              rdi_now;
  logic              ais_now;
  logic              oof_now;
  logic              ua1_now;
  logic              ptu_now;
  logic [2:0]        rpt_now;
  logic [3:0]        ti_now;
  logic [7:0]        gc_now;
  logic [7:0]        nr_now;
  logic [2:0]        nz_now;
  logic [ALIGN_W-1:0] align_now;
  logic              align_seen;

  always_ff @(posedge mclk) begin
    if (reset) begin
      primed <= 1'b0;
    end else if (ce) begin
      primed <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      los_now <= 1'b0;
      lof_now <= 1'b0;
      rdi_now <= 1'b0;
      ais_now <= 1'b0;
      oof_now <= 1'b0;
      ua1_now <= 1'b0;
      ptu_now <= 1'b0;
      rpt_now <= 3'h0;
      ti_now  <= 4'h0;
      gc_now  <= 8'h00;
      nr_now  <= 8'h00;
    end else if (ce) begin
      los_now <= signal_absent_pin;
      lof_now <= frame_lost;
      rdi_now <= remote_defect;
      ais_now <= alarm_ind;
      oof_now <= out_of_frame;
      ua1_now <= unframed_all_ones;
      ptu_now <= payload_unstable;
      rpt_now <= payload_type;
      ti_now  <= timing_source;
      gc_now  <= gc_byte_value;
      nr_now  <= nr_byte_value;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      nz_now <= 3'h0;
    end else if (ce) begin
      nz_now[B_REI_NZ] <= |remote_err_count;
      nz_now[B_PAR_NZ] <= |parity_err_count;
      nz_now[B_FRM_NZ] <= |framing_err_count;
    end
  end

  // ==========================================================================
  // Expected payload type, mismatch status and port gate
  logic [2:0] exp_payload;
  logic       port_status_irq_gate;
  logic [DATA_W-1:0] ept_merged;
  logic [DATA_W-1:0] gate_merged;

  assign ept_merged  = lane_merge({12'h000, exp_payload, 1'b0}, bus_wdat, bus_sel);
  assign gate_merged = lane_merge({15'h0000, port_status_irq_gate}, bus_wdat, bus_sel);

  always_ff @(posedge mclk) begin
    if (reset) begin
      exp_payload <= RST_EXP_PT;
    end else if (ce && wr_take && bus_idx == IDX_EXP_PAYLOAD) begin
      exp_payload <= ept_merged[EPT_LSB+2:EPT_LSB];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      port_status_irq_gate <= RST_GATE;
    end else if (ce && wr_take && bus_idx == IDX_PORT_GATE) begin
      port_status_irq_gate <= gate_merged[GATE_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      payload_mismatch <= 1'b0;
    end else if (ce) begin
      payload_mismatch <= (payload_type != exp_payload);
    end
  end

  // ==========================================================================
  // Previous values for change detection
  logic              los_was;
  logic              lof_was;
  logic              rdi_was;
  logic              ais_was;
  logic              oof_was;
  logic              ua1_was;
  logic              ptu_was;
  logic              ptm_was;
  logic [2:0]        rpt_was;
  logic [3:0]        ti_was;
  logic [7:0]        gc_was;
  logic [7:0]        nr_was;
  logic [2:0]        nz_was;

  always_ff @(posedge mclk) begin
    if (reset) begin
      los_was <= 1'b0;
      lof_was <= 1'b0;
      rdi_was <= 1'b0;
      ais_was <= 1'b0;
      oof_was <= 1'b0;
      ua1_was <= 1'b0;
      ptu_was <= 1'b0;
      ptm_was <= 1'b0;
      rpt_was <= 3'h0;
      ti_was  <= 4'h0;
      gc_was  <= 8'h00;
      nr_was  <= 8'h00;
      nz_was  <= 3'h0;
    end else if (ce) begin
      los_was <= los_now;
      lof_was <= lof_now;
      rdi_was <= rdi_now;
      ais_was <= ais_now;
      oof_was <= oof_now;
      ua1_was <= ua1_now;
      ptu_was <= ptu_now;
      ptm_was <= payload_mismatch;
      rpt_was <= rpt_now;
      ti_was  <= ti_now;
      gc_was  <= gc_now;
      nr_was  <= nr_now;
      nz_was  <= nz_now;
    end
  end

  // Alignment of the last counter reload; the very first reload only records it
  logic align_differs;

  assign align_differs = align_load & align_seen & (align_value != align_now);

  always_ff @(posedge mclk) begin
    if (reset) begin
      align_now  <= '0;
      align_seen <= 1'b0;
    end else if (ce && align_load) begin
      align_now  <= align_value;
      align_seen <= 1'b1;
    end
  end

  // ==========================================================================
  // Set terms for the latches
  logic [DATA_W-1:0] chg_set;
  logic [DATA_W-1:0] evt_set;

  always_comb begin
    chg_set = '0;
    if (primed) begin
      chg_set[B_TIMING]  = (ti_now != ti_was);
      chg_set[B_PT_UNST] = rise(ptu_now, ptu_was);
      chg_set[B_PT_MISM] = rise(payload_mismatch, ptm_was);
      chg_set[B_PT_CHG]  = (rpt_now != rpt_was);
      chg_set[B_UA1]     = ua1_now ^ ua1_was;
      chg_set[B_GC]      = (gc_now != gc_was);
      chg_set[B_NR]      = (nr_now != nr_was);
      chg_set[B_LOF]     = lof_now ^ lof_was;
      chg_set[B_RDI]     = rdi_now ^ rdi_was;
      chg_set[B_AIS]     = ais_now ^ ais_was;
      chg_set[B_OOF]     = oof_now ^ oof_was;
      chg_set[B_LOS]     = los_now ^ los_was;
    end
    chg_set[B_COFA] = align_differs;
  end

  always_comb begin
    evt_set = '0;
    evt_set[B_REI_EV] = remote_err_event;
    evt_set[B_PAR_EV] = parity_err_event;
    evt_set[B_FRM_EV] = framing_err_event;
    if (primed) begin
      evt_set[B_REI_NZ] = rise(nz_now[B_REI_NZ], nz_was[B_REI_NZ]);
      evt_set[B_PAR_NZ] = rise(nz_now[B_PAR_NZ], nz_was[B_PAR_NZ]);
      evt_set[B_FRM_NZ] = rise(nz_now[B_FRM_NZ], nz_was[B_FRM_NZ]);
    end
  end

  // ==========================================================================
  // Latched registers, write one to clear
  logic [DATA_W-1:0] chg_clr;
  logic [DATA_W-1:0] evt_clr;
  logic [DATA_W-1:0] chg_latched;
  logic [DATA_W-1:0] evt_latched;

  assign chg_clr = (wr_take && bus_idx == IDX_CHG_LATCHED) ?
                   (bus_wdat & lane_mask(bus_sel)) : '0;
  assign evt_clr = (wr_take && bus_idx == IDX_EVT_LATCHED) ?
                   (bus_wdat & lane_mask(bus_sel)) : '0;

  e3s_w1c_reg #(
    .W    (DATA_W),
    .MASK (MASK_CHG)
  ) u_chg_latch (
    .mclk  (mclk),
    .reset (reset),
    .ce    (ce),
    .set   (chg_set),
    .clr   (chg_clr),
    .q     (chg_latched)
  );

  e3s_w1c_reg #(
    .W    (DATA_W),
    .MASK (MASK_EVT)
  ) u_evt_latch (
    .mclk  (mclk),
    .reset (reset),
    .ce    (ce),
    .set   (evt_set),
    .clr   (evt_clr),
    .q     (evt_latched)
  );

  // ==========================================================================
  // Interrupt enables, same bit positions as the latches
  logic [DATA_W-1:0] irq_en_first;
  logic [DATA_W-1:0] irq_en_second;

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_en_first <= RST_IRQ_EN;
    end else if (ce && wr_take && bus_idx == IDX_IRQ_EN_FIRST) begin
      irq_en_first <= lane_merge(irq_en_first, bus_wdat, bus_sel) & MASK_CHG;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_en_second <= RST_IRQ_EN;
    end else if (ce && wr_take && bus_idx == IDX_IRQ_EN_SECOND) begin
      irq_en_second <= lane_merge(irq_en_second, bus_wdat, bus_sel) & MASK_EVT;
    end
  end

  // Port request: any set latch whose enable is 1, passed by the port gate
  always_ff @(posedge mclk) begin
    if (reset) begin
      port_irq <= 1'b0;
    end else if (ce) begin
      port_irq <= port_status_irq_gate &
                  (|(chg_latched & irq_en_first) |
                   |(evt_latched & irq_en_second));
    end
  end

  // ==========================================================================
  // Read mux
  logic [DATA_W-1:0] status_now;
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    status_now = '0;
    status_now[B_PT_UNST] = ptu_now;
    status_now[B_PT_MISM] = payload_mismatch;
    status_now[B_UA1]     = ua1_now;
    status_now[B_LOF]     = lof_now;
    status_now[B_RDI]     = rdi_now;
    status_now[B_AIS]     = ais_now;
    status_now[B_OOF]     = oof_now;
    status_now[B_LOS]     = los_now;
  end

  always_comb begin
    case (bus_idx)
      IDX_EXP_PAYLOAD:   rd_mux = {12'h000, exp_payload, 1'b0};
      IDX_STATUS_NOW:    rd_mux = status_now & MASK_STATUS;
      IDX_CNT_NONZERO:   rd_mux = {13'h0000, nz_now} & MASK_NONZERO;
      IDX_CHG_LATCHED:   rd_mux = chg_latched;
      IDX_EVT_LATCHED:   rd_mux = evt_latched;
      IDX_IRQ_EN_FIRST:  rd_mux = irq_en_first;
      IDX_IRQ_EN_SECOND: rd_mux = irq_en_second;
      IDX_MA_BYTE:       rd_mux = {9'h000, rpt_now, ti_now};
      IDX_NR_GC_BYTE:    rd_mux = {gc_now, nr_now};
      IDX_PORT_GATE:     rd_mux = {15'h0000, port_status_irq_gate};
      default:           rd_mux = '0;
    endcase
  end

  // ==========================================================================
  // Wishbone answer: ack one cycle after the request, then drop
  always_ff @(posedge mclk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce) begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req && !wb_ack_o) begin
        wb_dat_o <= {16'h0000, rd_mux};
      end
    end
  end

endmodule

// ===== e3s_pkg.sv
// Constants shared by the receive status, latch and interrupt enable bank
package e3s_pkg;

  // ==========================================================================
  // Widths
  localparam int DATA_W  = 16;
  localparam int CNT_W   = 16;
  localparam int IDX_W   = 8;
  localparam int WB_AW   = 32;
  localparam int WB_DW   = 32;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [IDX_W-1:0] IDX_EXP_PAYLOAD  = 8'h22;
  localparam logic [IDX_W-1:0] IDX_STATUS_NOW   = 8'h24;
  localparam logic [IDX_W-1:0] IDX_CNT_NONZERO  = 8'h26;
  localparam logic [IDX_W-1:0] IDX_CHG_LATCHED  = 8'h28;
  localparam logic [IDX_W-1:0] IDX_EVT_LATCHED  = 8'h2a;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN_FIRST = 8'h2c;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN_SECOND = 8'h2e;
  localparam logic [IDX_W-1:0] IDX_MA_BYTE      = 8'h30;
  localparam logic [IDX_W-1:0] IDX_NR_GC_BYTE   = 8'h32;
  localparam logic [IDX_W-1:0] IDX_PORT_GATE    = 8'h40;

  // ==========================================================================
  // Bit positions of the change latches, status and first enable register
  localparam int B_TIMING   = 13;
  localparam int B_PT_UNST  = 12;
  localparam int B_PT_MISM  = 11;
  localparam int B_PT_CHG   = 10;
  localparam int B_UA1      = 8;
  localparam int B_GC       = 7;
  localparam int B_NR       = 6;
  localparam int B_COFA     = 5;
  localparam int B_LOF      = 4;
  localparam int B_RDI      = 3;
  localparam int B_AIS      = 2;
  localparam int B_OOF      = 1;
  localparam int B_LOS      = 0;

  // Event latches and count-nonzero bits
  localparam int B_REI_EV   = 10;
  localparam int B_PAR_EV   = 9;
  localparam int B_FRM_EV   = 8;
  localparam int B_REI_NZ   = 2;
  localparam int B_PAR_NZ   = 1;
  localparam int B_FRM_NZ   = 0;

  // Field positions in the other registers
  localparam int EPT_LSB    = 1;
  localparam int RPT_LSB    = 4;
  localparam int TI_LSB     = 0;
  localparam int GC_LSB     = 8;
  localparam int NR_LSB     = 0;
  localparam int GATE_BIT   = 0;

  // ==========================================================================
  // Implemented bit masks
  localparam logic [DATA_W-1:0] MASK_CHG     = 16'h3dff;
  localparam logic [DATA_W-1:0] MASK_EVT     = 16'h0707;
  localparam logic [DATA_W-1:0] MASK_STATUS  = 16'h191f;
  localparam logic [DATA_W-1:0] MASK_NONZERO = 16'h0007;

  // ==========================================================================
  // Reset values
  localparam logic [DATA_W-1:0] RST_IRQ_EN   = 16'h0000;
  localparam logic [DATA_W-1:0] RST_LATCH    = 16'h0000;
  localparam logic [2:0]        RST_EXP_PT   = 3'h0;
  localparam logic              RST_GATE     = 1'b0;

endpackage

// ===== e3s_w1c_reg.sv
// Bank of sticky flags, set by hardware and cleared by writing one
module e3s_w1c_reg #(
  parameter int                W    = 16,
  parameter logic [W-1:0]      MASK = '1
) (
  input  wire logic            mclk,
  input  wire logic            reset,
  input  wire logic            ce,
  input  wire logic [W-1:0]    set,
  input  wire logic [W-1:0]    clr,
  output logic      [W-1:0]    q
);

  // ==========================================================================
  // Set wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '0;
    end else if (ce) begin
      q <= ((q & ~clr) | set) & MASK;
    end
  end

endmodule

// ===== e3s_rx_status_latch_irq_assertions.sv
// Checks on the bus answer, register reads and interrupt output of the latch bank
module e3s_rx_status_latch_irq_assertions (
  input wire logic                      mclk,
  input wire logic                      reset,
  input wire logic                      ce,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_we_i,
  input wire logic [e3s_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [e3s_pkg::WB_DW-1:0] wb_dat_o,
  input wire logic                      wb_ack_o,
  input wire logic [e3s_pkg::CNT_W-1:0] remote_err_count,
  input wire logic [e3s_pkg::CNT_W-1:0] parity_err_count,
  input wire logic [e3s_pkg::CNT_W-1:0] framing_err_count,
  input wire logic                      port_irq
);
  import e3s_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  wire logic [7:0]  idx    = wb_adr_i[9:2];
  wire logic        rd_req = wb_cyc_i && wb_stb_i && !wb_we_i;
  wire logic [47:0] cnt    = {remote_err_count, parity_err_count, framing_err_count};
  wire logic [2:0]  nz     = {|remote_err_count, |parity_err_count, |framing_err_count};
  wire logic        mapped = idx inside {IDX_EXP_PAYLOAD, IDX_STATUS_NOW, IDX_CNT_NONZERO,
    IDX_CHG_LATCHED, IDX_EVT_LATCHED, IDX_IRQ_EN_FIRST, IDX_IRQ_EN_SECOND, IDX_MA_BYTE,
    IDX_NR_GC_BYTE, IDX_PORT_GATE};

  // ==========================================================================
  // Bus answer
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && ce && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in the next cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_unmapped_zero: assert property (wb_ack_o && $past(rd_req && !mapped) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");

  // ==========================================================================
  // Register contents
  a_chg_mask: assert property (wb_ack_o && $past(rd_req && idx == IDX_CHG_LATCHED)
    |-> (wb_dat_o[15:0] & ~MASK_CHG) == 16'h0000)
    else $error("reserved change latch bit set");
  a_evt_mask: assert property (wb_ack_o && $past(rd_req && idx == IDX_EVT_LATCHED)
    |-> (wb_dat_o[15:0] & ~MASK_EVT) == 16'h0000)
    else $error("reserved event latch bit set");
  a_nonzero_read: assert property (
    wb_ack_o && $past(rd_req && idx == IDX_CNT_NONZERO) && $past(cnt, 1) == $past(cnt, 2)
    && $past(cnt, 2) == $past(cnt, 3) |-> wb_dat_o[2:0] == $past(nz, 2))
    else $error("count nonzero bits wrong");
  a_irq_reset: assert property ($fell(reset) |-> !port_irq ##1 !port_irq)
    else $error("interrupt raised right after reset");

  c_chg_read: cover property (wb_ack_o && $past(rd_req && idx == IDX_CHG_LATCHED));
  c_irq_rise: cover property ($rose(port_irq));
  c_write: cover property (wb_ack_o && $past(wb_we_i));
endmodule

// ===== testbench.sv
// Register-level testbench for the receive status latch bank
bind e3s_rx_status_latch_irq e3s_rx_status_latch_irq_assertions u_chk (.mclk, .reset, .ce,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .remote_err_count,
  .parity_err_count, .framing_err_count, .port_irq);

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import e3s_pkg::*;

  logic        mclk, reset, ce, cyc, stb, we, ald, ack, irq, pmis;
  logic [3:0]  sel, ts;
  logic [2:0]  pt, ev;
  logic [7:0]  gc, nr;
  logic [15:0] st, av, c_rei, c_par, c_frm;
  logic [31:0] adr, wdat, dout, rdat;
  int          err_count, checks;
  int          abit[6] = '{B_LOS, B_OOF, B_AIS, B_RDI, B_LOF, B_UA1};

  e3s_rx_status_latch_irq u_e3s_rx_status_latch_irq (
    .mclk(mclk), .reset(reset), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
    .signal_absent_pin(st[0]), .out_of_frame(st[1]), .alarm_ind(st[2]),
    .remote_defect(st[3]), .frame_lost(st[4]), .unframed_all_ones(st[8]),
    .payload_unstable(st[12]), .payload_type(pt), .timing_source(ts), .gc_byte_value(gc),
    .nr_byte_value(nr), .align_load(ald), .align_value(av), .remote_err_event(ev[2]),
    .parity_err_event(ev[1]), .framing_err_event(ev[0]), .remote_err_count(c_rei),
    .parity_err_count(c_par), .framing_err_count(c_frm), .payload_mismatch(pmis),
    .port_irq(irq));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ==========================================================================
  // Tasks
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h3;
    adr <= {22'h0, idx, 2'h0};
    wdat <= {16'h0, d};
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [15:0] e);
    bus(1'b0, idx, 16'h0);
    check($sformatf("reg_%h", idx), rdat[15:0], e);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic settle();
    repeat (4) @(posedge mclk);
  endtask

  // Read a latch register, then clear all its bits
  task automatic lchk(input logic [7:0] idx, input logic [15:0] e);
    rd(idx, e);
    wr(idx, 16'hffff);
  endtask

  task automatic align(input logic [15:0] v);
    @(posedge mclk);
    ald <= 1'b1;
    av <= v;
    @(posedge mclk);
    ald <= 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #100us;
    err_count++;
    print_verdict();
  end

  // ==========================================================================
  // Tests
  initial begin
    {reset, ce} = 2'b11;
    {cyc, stb, we, ald, sel, ts, pt, ev, gc, nr} = '0;
    {st, av, c_rei, c_par, c_frm, adr, wdat} = '0;
    err_count = 0;
    checks = 0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    rd(IDX_CHG_LATCHED, RST_LATCH);
    rd(IDX_EVT_LATCHED, RST_LATCH);
    rd(IDX_IRQ_EN_FIRST, RST_IRQ_EN);
    rd(8'h3f, 16'h0000);
    $display("test reset done");
    foreach (abit[i]) begin
      st[abit[i]] <= 1'b1;
      settle();
      lchk(IDX_CHG_LATCHED, 16'h1 << abit[i]);
      st[abit[i]] <= 1'b0;
      settle();
      lchk(IDX_CHG_LATCHED, 16'h1 << abit[i]);
    end
    st[B_PT_UNST] <= 1'b1;
    settle();
    lchk(IDX_CHG_LATCHED, 16'h1000);
    st[B_PT_UNST] <= 1'b0;
    settle();
    rd(IDX_CHG_LATCHED, 16'h0000);
    $display("test alarms done");
    pt <= 3'h5;
    settle();
    check("payload_mismatch", {15'h0, pmis}, 16'h0001);
    lchk(IDX_CHG_LATCHED, 16'h0c00);
    wr(IDX_EXP_PAYLOAD, 16'h000a);
    settle();
    check("payload_mismatch", {15'h0, pmis}, 16'h0000);
    rd(IDX_CHG_LATCHED, 16'h0000);
    wr(IDX_EXP_PAYLOAD, 16'h0000);
    settle();
    lchk(IDX_CHG_LATCHED, 16'h0800);
    ts <= 4'h9;
    settle();
    lchk(IDX_CHG_LATCHED, 16'h2000);
    gc <= 8'ha5;
    settle();
    lchk(IDX_CHG_LATCHED, 16'h0080);
    nr <= 8'h3c;
    settle();
    lchk(IDX_CHG_LATCHED, 16'h0040);
    rd(IDX_NR_GC_BYTE, 16'ha53c);
    rd(IDX_MA_BYTE, 16'h0059);
    $display("test payload done");
    align(16'h0010);
    align(16'h0010);
    rd(IDX_CHG_LATCHED, 16'h0000);
    align(16'h0011);
    lchk(IDX_CHG_LATCHED, 16'h0020);
    $display("test align done");
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      ev <= 3'h1 << i;
      @(posedge mclk);
      ev <= 3'h0;
      lchk(IDX_EVT_LATCHED, 16'h0100 << i);
    end
    c_par <= 16'h0001;
    settle();
    rd(IDX_CNT_NONZERO, 16'h0002);
    lchk(IDX_EVT_LATCHED, 16'h0002);
    c_rei <= 16'hffff;
    c_frm <= 16'h8000;
    settle();
    rd(IDX_CNT_NONZERO, 16'h0007);
    lchk(IDX_EVT_LATCHED, 16'h0005);
    {c_rei, c_par, c_frm} <= '0;
    settle();
    rd(IDX_CNT_NONZERO, 16'h0000);
    rd(IDX_EVT_LATCHED, 16'h0000);
    $display("test errors done");
    wr(IDX_IRQ_EN_FIRST, 16'hffff);
    rd(IDX_IRQ_EN_FIRST, MASK_CHG);
    wr(IDX_IRQ_EN_FIRST, 16'h0001);
    st[B_LOS] <= 1'b1;
    settle();
    rd(IDX_STATUS_NOW, 16'h0801);
    check("port_irq", {15'h0, irq}, 16'h0000);
    wr(IDX_PORT_GATE, 16'h0001);
    settle();
    check("port_irq", {15'h0, irq}, 16'h0001);
    wr(IDX_IRQ_EN_FIRST, 16'h0002);
    settle();
    check("port_irq", {15'h0, irq}, 16'h0000);
    wr(IDX_IRQ_EN_FIRST, 16'h0001);
    wr(IDX_CHG_LATCHED, 16'hffff);
    settle();
    check("port_irq", {15'h0, irq}, 16'h0000);
    wr(IDX_IRQ_EN_SECOND, 16'hffff);
    rd(IDX_IRQ_EN_SECOND, MASK_EVT);
    wr(IDX_IRQ_EN_SECOND, 16'h0100);
    ev <= 3'h1;
    @(posedge mclk);
    ev <= 3'h0;
    settle();
    check("port_irq", {15'h0, irq}, 16'h0001);
    wr(IDX_EVT_LATCHED, 16'hffff);
    settle();
    check("port_irq", {15'h0, irq}, 16'h0000);
    $display("test irq done");
    // Pulse seen only while frozen must not be reported
    ce <= 1'b0;
    st[B_OOF] <= 1'b1;
    settle();
    st[B_OOF] <= 1'b0;
    settle();
    ce <= 1'b1;
    settle();
    rd(IDX_CHG_LATCHED, 16'h0000);
    $display("test freeze done");
    print_verdict();
  end
endmodule
